// file: ascii_bcd_decode.sv
`timescale 1ns/1ps
module ascii_bcd_decode
	import bcd_out_pkg::*;
(
	input wire logic [7:0] ch,
	input wire logic setup_mode,
	output char_info_t info
);
	wire is_num = (ch >= ASC_ZERO) && (ch <= ASC_NINE);
	wire is_space = ch == ASC_SPACE;
	wire is_minus = ch == ASC_MINUS;
	wire is_point = ch == ASC_POINT;
	wire is_exp = ch == ASC_EXP;
	wire is_sign = is_space | is_minus | is_point | is_exp;
	wire [DIGIT_W-1:0] sign_code = is_space ? CODE_SPACE :
		is_minus ? CODE_MINUS :
		is_point ? CODE_POINT : CODE_EXP;

	assign info.numeral = is_num;
	assign info.permitted = is_num | is_sign;
	// setup mode drops the sign characters entirely
	assign info.store = is_num | (is_sign & ~setup_mode);
	// low nibble of an ascii numeral is already 8421 bcd
	assign info.code = is_num ? ch[DIGIT_W-1:0] : sign_code;
endmodule

// file: bcd_digit_output_port.sv
// Contract
// - ascii characters become 8421 bcd digits
// - store strobe latches digit, second strobe advances
// - ten separate four-bit output latches
// - fill from digit nine down to zero
// - recorder terminator starts the store pulse
// - recorder discards digits beyond the tenth
// - recorder load during busy stalls the controller
// - setup end-of-word signal starts store pulse
// - jumpers choose halting until instrument programmed
// - setup register change before busy release stalls
// - no busy: loading resumes after resume time
// - output word held until next command
// - single-word command clears after one word
// - continuous command repeats words until stopped
// - continuous command ignored in setup mode
// - stop command ends continuous output
// - recorder codes signs, setup ignores them
// - pulse ends by timeout or late busy; the code also ends it at the resume time when busy never comes
//
// Local design decisions: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
module bcd_digit_output_port
	import bcd_out_pkg::*;
#(
	parameter int PULSE_CYC = PULSE_MAX_CYC,
	parameter int RESUME_CYCLES = RESUME_CYC
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic busy_i,
	output logic store_data_o,
	output logic [DIGITS*DIGIT_W-1:0] digits_o
);
	wb_req_t req;
	char_info_t info;
	logic [2:0] cfg_q;
	logic single_q, cont_q, full_q, fresh_q, stored_q, bad_q;
	logic [POS_W-1:0] pos_q;
	logic [DIGIT_W-1:0] digit_q [DIGITS];
	logic [31:0] rdata;
	logic blocked;

	assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
		dat: wb_dat_i, sel: wb_sel_i};

	// address decode
	wire hit = req.cyc && req.stb && !wb_ack_o;
	wire sel_cmd = req.adr == REG_CMD;
	wire sel_cfg = req.adr == REG_CFG;
	wire sel_char = req.adr == REG_CHAR;
	wire sel_adv = req.adr == REG_ADV;
	wire sel_stat = req.adr == REG_STAT;
	wire sel_dlo = req.adr == REG_DLO;
	wire sel_dhi = req.adr == REG_DHI;

	wire setup_mode = cfg_q[CFG_MODE_BIT];
	// both jumpers in place: every command waits for the instrument
	wire halt_all = cfg_q[CFG_HALT_A_BIT] & cfg_q[CFG_HALT_B_BIT];

	// a held ack is how the controller's main program is halted
	wire load_reg = sel_char | sel_adv;
	wire stall_rec = !setup_mode && (load_reg || sel_cmd);
	wire stall_set = setup_mode && (load_reg || (halt_all && sel_cmd));
	wire stall = blocked && req.we && (stall_rec || stall_set);
	wire take = hit && !stall;
	wire wr = take && req.we;
	wire wr_lo = wr && req.sel[0];
	wire wr_hi = wr && req.sel[1];

	wire cmd_wr = wr_lo && sel_cmd;
	wire cmd_stop = cmd_wr && req.dat[CMD_STOP_BIT];
	wire cmd_single = cmd_wr && req.dat[CMD_SINGLE_BIT] && !cmd_stop;
	// continuous output cannot be started in setup mode
	wire cmd_cont = cmd_wr && req.dat[CMD_CONT_BIT] && !cmd_stop && !setup_mode;
	wire active = single_q | cont_q;
	wire new_cmd = cmd_single | cmd_cont;

	ascii_bcd_decode u_decode (
		.ch(req.dat[7:0]),
		.setup_mode(setup_mode),
		.info(info)
	);

	wire char_wr = wr_lo && sel_char && active;
	// characters past the tenth digit are dropped while the word stays legal
	wire store_ok = char_wr && info.store && !full_q;
	wire bad_char = char_wr && !info.permitted;
	wire adv_ok = wr_lo && sel_adv && active && stored_q && !full_q;
	wire char_end = char_wr && wr_hi && req.dat[CHAR_END_BIT];
	// end of word: terminator character or end signal, either one accepted in both modes
	wire end_ok = active && !cmd_stop && (char_end || (cmd_wr && req.dat[CMD_END_BIT]));

	store_pulse_timer #(
		.PULSE_CYC(PULSE_CYC),
		.RESUME_CYCLES(RESUME_CYCLES)
	) u_timer (
		.clk(clk),
		.resetn(resetn),
		.start(end_ok),
		.busy_i(busy_i),
		.pulse_q(store_data_o),
		.blocked(blocked)
	);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cfg_q <= CFG_RESET;
			single_q <= 1'b0;
			cont_q <= 1'b0;
		end else begin
			if (wr_lo && sel_cfg) cfg_q <= req.dat[2:0];
			// single word clears itself once its word is sent
			if (cmd_stop || (end_ok && !cmd_single)) single_q <= 1'b0;
			else if (cmd_single) single_q <= 1'b1;
			// continuous survives word ends until a stop
			if (cmd_stop || (setup_mode && !cont_q)) cont_q <= 1'b0;
			else if (cmd_cont) cont_q <= 1'b1;
		end
	end

	// decade counter: counts down from the most significant position
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pos_q <= TOP_POS;
			full_q <= 1'b0;
			fresh_q <= 1'b1;
			stored_q <= 1'b0;
			bad_q <= 1'b0;
		end else begin
			if (new_cmd || end_ok) begin
				pos_q <= TOP_POS;
				full_q <= 1'b0;
				fresh_q <= 1'b1;
				stored_q <= 1'b0;
			end else if (adv_ok) begin
				pos_q <= (pos_q == LAST_POS) ? pos_q : pos_q - 1'b1;
				full_q <= pos_q == LAST_POS;
				stored_q <= 1'b0;
			end else if (store_ok) begin
				fresh_q <= 1'b0;
				stored_q <= 1'b1;
			end
			if (new_cmd) bad_q <= 1'b0;
			else if (bad_char) bad_q <= 1'b1;
		end
	end

	// ten latches; the first digit of a word blanks the rest of the old word
	genvar gi;
	generate
		for (gi = 0; gi < DIGITS; gi++) begin : g_latch
			wire here = pos_q == POS_W'(gi);
			always_ff @(posedge clk) begin
				if (!resetn) begin
					digit_q[gi] <= '0;
				end else if (store_ok && here) begin
					digit_q[gi] <= info.code;
				end else if (store_ok && fresh_q) begin
					digit_q[gi] <= '0;
				end
			end
			// word stays on the pins until the first digit of the next word is stored
			assign digits_o[gi*DIGIT_W +: DIGIT_W] = digit_q[gi];
		end
	endgenerate

	wire [31:0] stat = {16'h0000, 3'h0, bad_q, pos_q, busy_i, blocked,
		store_data_o, full_q, fresh_q, setup_mode, cont_q, single_q};
	assign rdata = sel_stat ? stat :
		sel_cfg ? {29'h0, cfg_q} :
		sel_dlo ? digits_o[31:0] :
		sel_dhi ? {24'h000000, digits_o[DIGITS*DIGIT_W-1:32]} : 32'h0000_0000;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= take;
			wb_dat_o <= (take && !req.we) ? rdata : 32'h0000_0000;
		end
	end

	a_ack_single: assert property (@(posedge clk) disable iff (!resetn)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held for more than one cycle");
	a_busy_stalls: assert property (@(posedge clk) disable iff (!resetn)
		hit && req.we && sel_char && blocked |=> !wb_ack_o)
		else $error("character write acknowledged while busy");
	a_single_clears: assert property (@(posedge clk) disable iff (!resetn)
		end_ok && !cmd_single |=> !single_q)
		else $error("single word command did not clear");
	a_cont_keeps: assert property (@(posedge clk) disable iff (!resetn)
		cont_q && !cmd_stop && !setup_mode |=> cont_q)
		else $error("continuous command dropped without stop");
	a_cont_setup: assert property (@(posedge clk) disable iff (!resetn)
		setup_mode && !cont_q |=> !cont_q)
		else $error("continuous command accepted in setup mode");
	a_stop_clears: assert property (@(posedge clk) disable iff (!resetn)
		cmd_stop |=> !cont_q && !single_q)
		else $error("stop did not clear the commands");
	a_digit_store: assert property (@(posedge clk) disable iff (!resetn)
		store_ok |=> digit_q[$past(pos_q)] == $past(info.code))
		else $error("stored digit does not match the character");
	a_word_restart: assert property (@(posedge clk) disable iff (!resetn)
		end_ok |=> pos_q == TOP_POS && fresh_q && !full_q)
		else $error("decade counter not back at the top");
	a_hold_word: assert property (@(posedge clk) disable iff (!resetn)
		!store_ok |=> $stable(digits_o))
		else $error("output word changed without a store");
	a_full_drop: assert property (@(posedge clk) disable iff (!resetn)
		full_q && char_wr |=> $stable(digits_o))
		else $error("digit beyond the tenth was stored");
	a_end_pulse: assert property (@(posedge clk) disable iff (!resetn)
		end_ok && !blocked |=> store_data_o)
		else $error("word end gave no store pulse");

	// bus answer: one ack per taken request, read data only beside it
	a_take_acks: assert property (@(posedge clk) disable iff (!resetn)
		take |=> wb_ack_o)
		else $error("taken request not acknowledged");
	a_read_data: assert property (@(posedge clk) disable iff (!resetn)
		take && !req.we |=> wb_dat_o == $past(rdata))
		else $error("read data does not match the selected register");
	a_dat_idle: assert property (@(posedge clk) disable iff (!resetn)
		!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data driven without ack");
	a_read_free: assert property (@(posedge clk) disable iff (!resetn)
		hit && !req.we |=> wb_ack_o)
		else $error("read was stalled");
	a_rec_stalls: assert property (@(posedge clk) disable iff (!resetn)
		hit && req.we && !setup_mode && (sel_cmd || sel_adv) && blocked |=> !wb_ack_o)
		else $error("recorder command acknowledged while busy");
	a_setup_stalls: assert property (@(posedge clk) disable iff (!resetn)
		hit && req.we && setup_mode && (sel_char || sel_adv) && blocked |=> !wb_ack_o)
		else $error("register change acknowledged before busy release");
	a_halt_jumpers: assert property (@(posedge clk) disable iff (!resetn)
		hit && req.we && setup_mode && sel_cmd && blocked && halt_all |=> !wb_ack_o)
		else $error("command not halted with both jumpers set");
	a_no_halt: assert property (@(posedge clk) disable iff (!resetn)
		hit && req.we && setup_mode && sel_cmd && !halt_all |=> wb_ack_o)
		else $error("command halted without the jumpers");
	a_busy_hold: assert property (@(posedge clk) disable iff (!resetn)
		blocked && busy_i && !store_data_o |=> blocked)
		else $error("loading released while busy");

	// counter walks down one step per advance and stops at digit zero
	a_adv_step: assert property (@(posedge clk) disable iff (!resetn)
		adv_ok && pos_q != LAST_POS |=> pos_q == $past(pos_q) - 1'b1)
		else $error("decade counter did not step down");
	a_adv_full: assert property (@(posedge clk) disable iff (!resetn)
		adv_ok && pos_q == LAST_POS |=> full_q && pos_q == LAST_POS)
		else $error("tenth advance did not mark the word full");
	a_pos_range: assert property (@(posedge clk) disable iff (!resetn)
		pos_q <= TOP_POS)
		else $error("decade counter outside the ten latches");
	a_first_blanks: assert property (@(posedge clk) disable iff (!resetn)
		store_ok && fresh_q |=> digits_o[(DIGITS-1)*DIGIT_W-1:0] == '0)
		else $error("first digit did not blank the old word");
	a_numeral_nibble: assert property (@(posedge clk) disable iff (!resetn)
		store_ok && info.numeral |=> digit_q[$past(pos_q)] == $past(req.dat[3:0]))
		else $error("numeral digit is not the low nibble");
	a_point_code: assert property (@(posedge clk) disable iff (!resetn)
		store_ok && !setup_mode && req.dat[7:0] == ASC_POINT |=>
		digit_q[$past(pos_q)] == CODE_POINT)
		else $error("decimal point not given its recorder code");
	a_setup_signs: assert property (@(posedge clk) disable iff (!resetn)
		char_wr && setup_mode && !info.numeral |=> $stable(digits_o))
		else $error("sign character stored in setup mode");
	a_cmd_keeps: assert property (@(posedge clk) disable iff (!resetn)
		new_cmd |=> $stable(digits_o))
		else $error("new command disturbed the held word");
	a_single_starts: assert property (@(posedge clk) disable iff (!resetn)
		cmd_single |=> single_q)
		else $error("single word command not taken");
	a_cont_starts: assert property (@(posedge clk) disable iff (!resetn)
		cmd_cont |=> cont_q)
		else $error("continuous command not taken");
	a_setup_pulse: assert property (@(posedge clk) disable iff (!resetn)
		end_ok && setup_mode && !blocked |=> store_data_o)
		else $error("setup word end gave no store pulse");
	a_pulse_cause: assert property (@(posedge clk) disable iff (!resetn)
		$rose(store_data_o) |-> $past(end_ok))
		else $error("store pulse without a word end");
	a_no_idle_pulse: assert property (@(posedge clk) disable iff (!resetn)
		!active && !blocked |=> !store_data_o)
		else $error("store pulse with no command active");

	c_ten_digits: cover property (@(posedge clk) disable iff (!resetn)
		adv_ok && pos_q == LAST_POS);
	c_cont_two_words: cover property (@(posedge clk) disable iff (!resetn)
		cont_q && end_ok ##1 cont_q && !single_q);
	c_stall: cover property (@(posedge clk) disable iff (!resetn)
		hit && stall ##1 hit && stall);
endmodule

// file: bcd_digit_output_port_test.sv
`timescale 1ns/1ps
module bcd_digit_output_port_test;
	import bcd_out_pkg::*;
	logic clk, resetn, cyc, stb, we, busy, respond, ack, store_data, sd_prev;
	logic [ADR_W-1:0] adr;
	logic [31:0] dat_i, dat_o;
	logic [3:0] sel;
	logic [39:0] digits, e;
	logic [39:0] exp_word[$];
	logic [31:0] exp_rd[$];
	logic [31:0] exp_msk[$];
	int error_cnt, check_count, cycles, plen, run, lat;

	bcd_digit_output_port #(.PULSE_CYC(2000), .RESUME_CYCLES(1500)) i_bcd_digit_output_port (
		.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_dat_i(dat_i), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.busy_i(busy), .store_data_o(store_data), .digits_o(digits));
	recorder_model i_recorder_model (.clk(clk), .respond(respond), .store_data(store_data),
		.busy(busy));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic cmp_val(input logic [39:0] ex, input logic [39:0] g);
		check_count++;
		if (g !== ex) begin
			error_cnt++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, ex, g);
		end
	endtask

	task automatic cmp_in(input int lo, input int hi, input int g);
		check_count++;
		if (g < lo || g > hi) begin
			error_cnt++;
			$display("[FAIL] t=%0t exp=%h..%h got=%h", $time, lo, hi, g);
		end
	endtask

	task automatic print_verdict;
		$display("checks=%0d mismatches=%0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_i <= d;
		sel <= 4'hF;
		lat = 0;
		do begin
			@(posedge clk);
			lat++;
		end while (ack !== 1'b1 && lat < 5000);
		if (ack !== 1'b1) error_cnt++;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic rd(input logic [ADR_W-1:0] a, input logic [31:0] ex, input logic [31:0] m);
		exp_rd.push_back(ex);
		exp_msk.push_back(m);
		wb(1'b0, a, 32'h0);
	endtask

	// expected word is built here, pushed just before the end command
	// term: the last character carries the end mark instead of an end command
	task automatic send_word(input string s, input bit setup, input bit term = 1'b0);
		logic [3:0] c;
		logic [7:0] ch;
		int pos;
		e = '0;
		pos = 9;
		foreach (s[i]) begin
			ch = s[i];
			case (ch)
				ASC_SPACE: c = CODE_SPACE;
				ASC_MINUS: c = CODE_MINUS;
				ASC_POINT: c = CODE_POINT;
				ASC_EXP: c = CODE_EXP;
				default: c = ch[3:0];
			endcase
			if (!(setup && ch inside {ASC_SPACE, ASC_MINUS, ASC_POINT, ASC_EXP}) && pos >= 0) begin
				e[pos*4 +: 4] = c;
				pos--;
			end
			if (term && i == s.len() - 1) begin
				exp_word.push_back(e);
				wb(1'b1, REG_CHAR, {23'h0, 1'b1, ch});
			end else begin
				wb(1'b1, REG_CHAR, {24'h0, ch});
				wb(1'b1, REG_ADV, 32'h1);
			end
		end
		if (!term) begin
			exp_word.push_back(e);
			wb(1'b1, REG_CMD, 32'h8);
		end
	endtask

	task automatic wait_pulse;
		int n;
		n = 0;
		repeat (2) @(posedge clk);
		while (store_data !== 1'b0 && n < 4000) begin
			@(posedge clk);
			n++;
		end
		if (store_data !== 1'b0) error_cnt++;
		@(posedge clk);
	endtask

	function automatic string rand_num(input int n);
		string s;
		s = "";
		repeat (n) s = {s, "0"};
		foreach (s[i]) s[i] = byte'(8'h30 + $urandom_range(0, 9));
		return s;
	endfunction

	always @(posedge clk) begin
		sd_prev <= store_data;
		cycles <= cycles + 1;
		if (store_data === 1'b1) begin
			run <= run + 1;
		end else begin
			if (sd_prev === 1'b1) plen <= run;
			run <= 0;
		end
		if (store_data === 1'b1 && sd_prev !== 1'b1 && exp_word.size() > 0) begin
			cmp_val(exp_word.pop_front(), digits);
		end
		if (ack === 1'b1 && we === 1'b0 && exp_rd.size() > 0) begin
			cmp_val({8'h0, exp_rd.pop_front()}, {8'h0, dat_o & exp_msk.pop_front()});
		end
		if (cycles > 60000) begin
			error_cnt++;
			print_verdict();
		end
	end

	initial begin
		{cyc, stb, we, adr, dat_i, sel, resetn, sd_prev} = '0;
		respond = 1'b1;
		{error_cnt, check_count, cycles, plen, run, lat} = '0;
		void'($urandom(32'had5db28b));
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		wb(1'b1, REG_CMD, 32'h1);
		send_word(rand_num(11), 1'b0);
		rd(REG_STAT, 32'h0, 32'h3);
		wb(1'b1, REG_CHAR, 32'h31);
		cmp_in(1300, 1500, lat);
		rd(REG_DLO, e[31:0], 32'hFFFFFFFF);
		rd(REG_DHI, {24'h0, e[39:32]}, 32'hFFFFFFFF);
		cmp_in(1250, 1252, plen);
		$display("test full word done");
		wb(1'b1, REG_CMD, 32'h1);
		send_word("-5 .E", 1'b0);
		$display("test sign codes done");
		wb(1'b1, REG_CMD, 32'h2);
		send_word(rand_num(3), 1'b0);
		rd(REG_STAT, 32'h2, 32'h3);
		send_word(rand_num(4), 1'b0);
		wb(1'b1, REG_CMD, 32'h4);
		rd(REG_STAT, 32'h0, 32'h3);
		$display("test continuous done");
		wb(1'b1, REG_CFG, 32'h1);
		wb(1'b1, REG_CMD, 32'h2);
		rd(REG_STAT, 32'h4, 32'h7);
		wb(1'b1, REG_CMD, 32'h1);
		send_word("7-3", 1'b1);
		wb(1'b1, REG_CMD, 32'h1);
		cmp_in(2, 2, lat);
		wb(1'b1, REG_ADV, 32'h1);
		cmp_in(1300, 1500, lat);
		wb(1'b1, REG_CFG, 32'h7);
		send_word("4", 1'b1);
		wb(1'b1, REG_CMD, 32'h1);
		cmp_in(1300, 1500, lat);
		$display("test setup mode done");
		wb(1'b1, REG_CFG, 32'h0);
		respond <= 1'b0;
		wb(1'b1, REG_CMD, 32'h1);
		send_word("9", 1'b0, 1'b1);
		wait_pulse();
		cmp_in(1499, 1502, plen);
		$display("test silent device done");
		print_verdict();
	end
endmodule

// file: bcd_out_pkg.sv
package bcd_out_pkg;

	localparam int CLK_HZ = 125_000_000;
	localparam int DIGITS = 10;
	localparam int DIGIT_W = 4;
	localparam int ADR_W = 5;
	localparam int POS_W = 4;

	// register byte offsets
	localparam logic [ADR_W-1:0] REG_CMD = 5'h00;
	localparam logic [ADR_W-1:0] REG_CFG = 5'h04;
	localparam logic [ADR_W-1:0] REG_CHAR = 5'h08;
	localparam logic [ADR_W-1:0] REG_ADV = 5'h0C;
	localparam logic [ADR_W-1:0] REG_STAT = 5'h10;
	localparam logic [ADR_W-1:0] REG_DLO = 5'h14;
	localparam logic [ADR_W-1:0] REG_DHI = 5'h18;

	// command register bits
	localparam int CMD_SINGLE_BIT = 0;
	localparam int CMD_CONT_BIT = 1;
	localparam int CMD_STOP_BIT = 2;
	localparam int CMD_END_BIT = 3;
	// character register: bit 8 marks the last character of a word
	localparam int CHAR_END_BIT = 8;
	// configuration register bits
	localparam int CFG_MODE_BIT = 0;
	localparam int CFG_HALT_A_BIT = 1;
	localparam int CFG_HALT_B_BIT = 2;
	localparam logic [2:0] CFG_RESET = 3'h0;

	localparam logic [POS_W-1:0] TOP_POS = 4'h9;
	localparam logic [POS_W-1:0] LAST_POS = 4'h0;

	// timing
	localparam int PULSE_MAX_MS = 400;
	localparam int RESUME_MS = 300;
	localparam int BUSY_MIN_US = 10;
	localparam int PULSE_MAX_CYC = PULSE_MAX_MS * (CLK_HZ / 1000);
	localparam int RESUME_CYC = RESUME_MS * (CLK_HZ / 1000);
	localparam int BUSY_MIN_CYC = (BUSY_MIN_US * (CLK_HZ / 1000) + 999) / 1000;
	localparam int TMR_W = 26;

	// ascii codes and modified recorder codes
	localparam logic [7:0] ASC_ZERO = 8'h30;
	localparam logic [7:0] ASC_NINE = 8'h39;
	localparam logic [7:0] ASC_SPACE = 8'h20;
	localparam logic [7:0] ASC_MINUS = 8'h2D;
	localparam logic [7:0] ASC_POINT = 8'h2E;
	localparam logic [7:0] ASC_EXP = 8'h45;
	localparam logic [3:0] CODE_SPACE = 4'hF;
	localparam logic [3:0] CODE_MINUS = 4'hD;
	localparam logic [3:0] CODE_POINT = 4'hA;
	localparam logic [3:0] CODE_EXP = 4'hE;

	typedef struct packed {
		logic store;
		logic permitted;
		logic numeral;
		logic [DIGIT_W-1:0] code;
	} char_info_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [ADR_W-1:0] adr;
		logic [31:0] dat;
		logic [3:0] sel;
	} wb_req_t;

	typedef enum {ST_IDLE, ST_PULSE, ST_WAIT} pulse_state_t;

endpackage

// file: recorder_model.sv
`timescale 1ns/1ps
module recorder_model #(
	parameter int BUSY_DELAY = 20,
	parameter int BUSY_HOLD = 1400
) (
	input wire logic clk,
	input wire logic respond,
	input wire logic store_data,
	output logic busy
);
	logic seen_q;
	int cnt;
	initial begin
		busy = 1'b0;
		seen_q = 1'b0;
		cnt = 0;
	end
	// only a fresh pulse is answered; a silent device never raises busy
	always @(posedge clk) begin
		seen_q <= store_data;
		if (store_data && !seen_q && respond) begin
			cnt <= BUSY_DELAY + BUSY_HOLD;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
		busy <= (cnt > 0 && cnt <= BUSY_HOLD);
	end
endmodule

// file: store_pulse_timer.sv
`timescale 1ns/1ps
module store_pulse_timer
	import bcd_out_pkg::*;
#(
	parameter int PULSE_CYC = PULSE_MAX_CYC,
	parameter int RESUME_CYCLES = RESUME_CYC
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic start,
	input wire logic busy_i,
	output logic pulse_q,
	output logic blocked
);
	localparam int MIN_CYC = BUSY_MIN_CYC;
	pulse_state_t state_q, state_d;
	logic [TMR_W-1:0] cnt_q;
	logic seen_q;

	wire busy_end = busy_i && (cnt_q >= TMR_W'(MIN_CYC - 1));
	wire max_end = cnt_q >= TMR_W'(PULSE_CYC - 1);
	wire resume_end = !seen_q && !busy_i && (cnt_q >= TMR_W'(RESUME_CYCLES - 1));

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: if (start) state_d = ST_PULSE;
			// busy may cut the pulse short only after the minimum width
			ST_PULSE: begin
				if (busy_end || max_end) state_d = ST_WAIT;
				else if (resume_end) state_d = ST_IDLE;
			end
			ST_WAIT: if (!busy_i) state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
			seen_q <= 1'b0;
			pulse_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= (state_q == ST_PULSE) ? cnt_q + 1'b1 : '0;
			seen_q <= (state_q == ST_PULSE) && (seen_q || busy_i);
			pulse_q <= state_d == ST_PULSE;
		end
	end

	assign blocked = state_q != ST_IDLE;

	a_pulse_start: assert property (@(posedge clk) disable iff (!resetn)
		start && state_q == ST_IDLE |=> pulse_q)
		else $error("store pulse did not start");
	a_pulse_bound: assert property (@(posedge clk) disable iff (!resetn)
		pulse_q |-> cnt_q < TMR_W'(PULSE_CYC))
		else $error("store pulse longer than the maximum");
	a_busy_cut: assert property (@(posedge clk) disable iff (!resetn)
		$fell(pulse_q) |-> ($past(cnt_q) >= TMR_W'(MIN_CYC - 1)))
		else $error("store pulse ended before the minimum width");
	a_resume_free: assert property (@(posedge clk) disable iff (!resetn)
		state_q == ST_PULSE && resume_end && !max_end |=> !blocked)
		else $error("loading not released after the resume time");
	c_busy_end: cover property (@(posedge clk) disable iff (!resetn)
		state_q == ST_WAIT ##1 state_q == ST_IDLE);
	c_resume: cover property (@(posedge clk) disable iff (!resetn)
		state_q == ST_PULSE && resume_end);
endmodule
